// [core/strap_defines.svh]
// Offsets, field positions, reset values and timing counts for the strap latch
`ifndef STRAP_DEFINES_SVH
`define STRAP_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFF_CTRL       8'h00
`define OFF_ADV        8'h04
`define OFF_STAT       8'h08
`define OFF_MII        8'h0c
`define OFF_PINS       8'h10

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CTRL_SPEED     13
`define CTRL_ISO       10
`define CTRL_DUPLEX    8
`define ADV_100        7
`define ADV_10         5
`define MII_PUSH       4
`define MII_CLR        5
`define MII_PEND       8

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
// zero_unique, duplex, speed, iso, mode[2:0], addr_lo[2:0]
`define STRAP_RESET    10'b0_1_1_0_000_001
`define CTRL_RESET     16'h2000
`define ADV_RESET      16'h00a0
`define MODE_MII       3'b000
`define MODE_PAIR      3'b110
`define RESP_OK        2'b00
`define RESP_SLVERR    2'b10

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS  10
`define RXC_PERIOD_NS  40
`define RXC_HALF_CYC   ((`RXC_PERIOD_NS) / (2 * `CLK_PERIOD_NS))
`define CAP_DELAY      2'd3

`endif

// [core/strap_pkg.sv]
// Types shared by the strap latch and its bench
package strap_pkg;

    // Strap pins, one bit each
    typedef struct packed {
        logic       zero_unique;
        logic       duplex;
        logic       speed;
        logic       iso;
        logic [2:0] mode;
        logic [2:0] addr_lo;
    } strap_cfg_t;

    // Capture sequence, Gray coded
    typedef enum logic [1:0] {
        CAP_WAIT = 2'b00,
        CAP_TAKE = 2'b01,
        CAP_DONE = 2'b11
    } cap_state_t;

    typedef struct packed {
        logic        awvalid;
        logic [7:0]  awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [7:0]  araddr;
        logic        rready;
    } axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } axi_rsp_t;

    typedef struct packed {
        logic       txc;
        logic       txen;
        logic [3:0] txd;
    } mii_tx_t;

    typedef struct packed {
        logic       rxdv;
        logic [3:0] rxd;
    } mii_rx_t;

endpackage

// [core/strap_config_latch.sv]
// Strap capture at reset release, nibble interface qualification, AXI regs
`timescale 1ns/1ns
`include "strap_defines.svh"

// Operation
// - Receive nibbles change with supplied receive clock
// - Receive nibbles meaningful only while valid high
// - Transmit nibbles ignored while enable is low
// - Three address straps sampled at reset release
// - Default management address is one
// - Upper two address bits stay zero
// - Address zero unique only if strap high
// - Otherwise address zero acts as broadcast
// - Mode straps latched; 110 repeater pair
// - Isolate strap presets control bit 10
// - Speed strap presets bit 13, advertisement
// - High duplex strap means half duplex
// - Low duplex strap full, preset bit 8
// - Strap pins input in reset, outputs after
module strap_config_latch (
    input  wire logic                  clock,           // 100 MHz
    input  wire logic                  arst_n,          // Async reset
    input  wire strap_pkg::axi_req_t   axi_i,           // AXI4-Lite in
    output strap_pkg::axi_rsp_t        axi_o,           // AXI4-Lite out
    input  wire strap_pkg::strap_cfg_t strap_pin_i,     // Pin levels
    output strap_pkg::strap_cfg_t      strap_pin_o,     // Pin drive
    output strap_pkg::strap_cfg_t      strap_pin_oe_n,  // Low drives
    input  wire strap_pkg::mii_tx_t    mii_tx_i,        // From MAC
    output logic                       mii_rxc,         // Rx clock out
    output strap_pkg::mii_rx_t         mii_rx_o,        // To MAC
    output logic [4:0]                 mgmt_addr,       // Own address
    output logic                       addr_zero_bcast, // Zero is bcast
    output logic                       repeater_pair_mode, // Code 110
    output logic                       mode_reserved,   // Unused code
    output logic                       isolate,         // Ctrl bit 10
    output logic                       speed_100,       // Ctrl bit 13
    output logic                       full_duplex      // Ctrl bit 8
);
    import strap_pkg::*;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Byte-lane merge for the 16-bit control registers
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] d,
                                            input logic [3:0]  strb);
        merge16 = {strb[1] ? d[15:8] : old[15:8],
                   strb[0] ? d[7:0]  : old[7:0]};
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == `OFF_CTRL) || (a == `OFF_ADV) || (a == `OFF_STAT)
              || (a == `OFF_MII)  || (a == `OFF_PINS);
    endfunction

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    strap_cfg_t s1_r, s2_r, s3_r;
    mii_tx_t    t1_r, t2_r, t3_r;

    // Three stages; decisions only once stages two and three agree
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s1_r <= `STRAP_RESET;
            s2_r <= `STRAP_RESET;
            s3_r <= `STRAP_RESET;
            t1_r <= '0;
            t2_r <= '0;
            t3_r <= '0;
        end
        else
        begin
            s1_r <= strap_pin_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
            t1_r <= mii_tx_i;
            t2_r <= t1_r;
            t3_r <= t2_r;
        end
    end

    // ----------------------------------------------------------------
    // Strap capture
    // ----------------------------------------------------------------
    cap_state_t st_r;
    logic [1:0] wait_r;
    strap_cfg_t cfg_r;
    logic       bcast_r, pair_r, rsvd_r;
    wire        straps_agree = (s2_r == s3_r);
    wire        take = (st_r == CAP_TAKE) && straps_agree;

    // Wait for the pipeline to fill with post-reset pin levels
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_r   <= CAP_WAIT;
            wait_r <= 2'd0;
        end
        else
        begin
            case (st_r)
                CAP_WAIT:
                begin
                    wait_r <= wait_r + 2'd1;
                    if (wait_r == `CAP_DELAY - 2'd1)
                        st_r <= CAP_TAKE;
                end
                CAP_TAKE:
                    if (straps_agree)
                        st_r <= CAP_DONE;
                CAP_DONE: st_r <= CAP_DONE;
                default:  st_r <= CAP_WAIT;
            endcase
        end
    end

    // Latched settings; pull defaults until the capture
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cfg_r   <= `STRAP_RESET;
            bcast_r <= 1'b0;
            pair_r  <= 1'b0;
            rsvd_r  <= 1'b0;
        end
        else if (take)
        begin
            cfg_r   <= s3_r;
            // Zero is broadcast unless the unique strap was high
            bcast_r <= (s3_r.addr_lo == 3'd0)
                       && !s3_r.zero_unique;
            pair_r  <= (s3_r.mode == `MODE_PAIR);
            rsvd_r  <= (s3_r.mode != `MODE_MII) && (s3_r.mode != `MODE_PAIR);
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------------------------------
    axi_rsp_t    rsp_r;
    logic        aw_got_r, w_got_r;
    logic [7:0]  awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0]  wstrb_r;
    logic [15:0] ctrl_r, adv_r;
    strap_cfg_t  pins_r, oe_n_r;
    logic        tx_new_r, rx_pend_r;
    logic [3:0]  tx_nib_r, rx_nib_r;
    mii_rx_t     rx_r;
    logic        rxc_r;
    logic [1:0]  half_r;

    wire aw_hs  = axi_i.awvalid && rsp_r.awready;
    wire w_hs   = axi_i.wvalid && rsp_r.wready;
    wire ar_hs  = axi_i.arvalid && rsp_r.arready;
    wire do_wr  = aw_got_r && w_got_r;
    wire wr_ok  = mapped(awaddr_r);
    wire wr_ctl = do_wr && (awaddr_r == `OFF_CTRL);
    wire wr_adv = do_wr && (awaddr_r == `OFF_ADV);
    wire wr_mii = do_wr && (awaddr_r == `OFF_MII) && wstrb_r[0];
    wire wr_pin = do_wr && (awaddr_r == `OFF_PINS);
    wire rx_push  = wr_mii && wdata_r[`MII_PUSH];
    wire tx_clear = wr_mii && wdata_r[`MII_CLR];

    // Read data selection
    wire [31:0] stat_word = {18'h0, rx_pend_r, (st_r == CAP_DONE),
                             pair_r, rsvd_r, bcast_r, cfg_r.zero_unique,
                             cfg_r.mode, 2'b00, cfg_r.addr_lo};
    wire [31:0] mii_word  = {23'h0, rx_pend_r, 3'h0, tx_new_r, tx_nib_r};
    wire [31:0] rd_word   =
        (axi_i.araddr == `OFF_CTRL) ? {16'h0, ctrl_r} :
        (axi_i.araddr == `OFF_ADV)  ? {16'h0, adv_r}  :
        (axi_i.araddr == `OFF_STAT) ? stat_word       :
        (axi_i.araddr == `OFF_MII)  ? mii_word        :
        (axi_i.araddr == `OFF_PINS) ? {22'h0, pins_r} : 32'h0;

    // Write side: address and data in either order, one at a time
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            aw_got_r <= 1'b0;
            w_got_r  <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r  <= 32'h0;
            wstrb_r  <= 4'h0;
            rsp_r    <= '0;
            rsp_r.awready <= 1'b1;
            rsp_r.wready  <= 1'b1;
            rsp_r.arready <= 1'b1;
        end
        else
        begin
            if (aw_hs)
            begin
                aw_got_r      <= 1'b1;
                awaddr_r      <= axi_i.awaddr;
                rsp_r.awready <= 1'b0;
            end
            if (w_hs)
            begin
                w_got_r      <= 1'b1;
                wdata_r      <= axi_i.wdata;
                wstrb_r      <= axi_i.wstrb;
                rsp_r.wready <= 1'b0;
            end
            if (do_wr)
            begin
                aw_got_r     <= 1'b0;
                w_got_r      <= 1'b0;
                rsp_r.bvalid <= 1'b1;
                rsp_r.bresp  <= wr_ok ? `RESP_OK : `RESP_SLVERR;
            end
            else if (rsp_r.bvalid && axi_i.bready)
            begin
                rsp_r.bvalid  <= 1'b0;
                rsp_r.awready <= 1'b1;
                rsp_r.wready  <= 1'b1;
            end
            if (ar_hs)
            begin
                rsp_r.arready <= 1'b0;
                rsp_r.rvalid  <= 1'b1;
                rsp_r.rdata   <= rd_word;
                rsp_r.rresp   <= mapped(axi_i.araddr) ? `RESP_OK
                                                      : `RESP_SLVERR;
            end
            else if (rsp_r.rvalid && axi_i.rready)
            begin
                rsp_r.rvalid  <= 1'b0;
                rsp_r.arready <= 1'b1;
            end
        end
    end

    // Control words: strap preset once, software may rewrite after
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ctrl_r <= `CTRL_RESET;
            adv_r  <= `ADV_RESET;
            pins_r <= '0;
        end
        else
        begin
            if (take)
            begin
                ctrl_r[`CTRL_ISO]    <= s3_r.iso;
                ctrl_r[`CTRL_SPEED]  <= s3_r.speed;
                ctrl_r[`CTRL_DUPLEX] <= !s3_r.duplex;
                adv_r[`ADV_100]      <= s3_r.speed;
            end
            else if (wr_ctl)
                ctrl_r <= merge16(ctrl_r, wdata_r, wstrb_r);
            if (wr_adv)
                adv_r <= merge16(adv_r, wdata_r, wstrb_r);
            if (wr_pin && wstrb_r[0])
                pins_r[7:0] <= wdata_r[7:0];
            if (wr_pin && wstrb_r[1])
                pins_r[9:8] <= wdata_r[9:8];
        end
    end

    // Pins are inputs until the capture is over, then they drive
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            oe_n_r <= '1;
        else
            oe_n_r <= (st_r == CAP_DONE) ? '0 : '1;
    end

    // ----------------------------------------------------------------
    // Nibble paths
    // ----------------------------------------------------------------
    wire txc_agree = (t2_r.txc == t3_r.txc);
    logic txc_f_r;
    wire tx_rise = txc_agree && t3_r.txc && !txc_f_r;
    wire rx_fall = (half_r == 2'(`RXC_HALF_CYC - 1)) && rxc_r;

    // Transmit: take a nibble on each filtered clock rise with enable
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            txc_f_r  <= 1'b0;
            tx_nib_r <= 4'h0;
            tx_new_r <= 1'b0;
        end
        else
        begin
            if (txc_agree)
                txc_f_r <= t3_r.txc;
            if (tx_rise && t3_r.txen)
                tx_nib_r <= t3_r.txd;
            // New nibble wins over a clear in the same cycle
            tx_new_r <= (tx_rise && t3_r.txen) || (tx_new_r && !tx_clear);
        end
    end

    // Receive: clock made here; data moves on its falling edge
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            half_r    <= 2'd0;
            rxc_r     <= 1'b0;
            rx_r      <= '0;
            rx_pend_r <= 1'b0;
            rx_nib_r  <= 4'h0;
        end
        else
        begin
            half_r <= (half_r == 2'(`RXC_HALF_CYC - 1)) ? 2'd0
                                                       : half_r + 2'd1;
            if (half_r == 2'(`RXC_HALF_CYC - 1))
                rxc_r <= !rxc_r;
            if (rx_fall)
                rx_r <= rx_pend_r ? {1'b1, rx_nib_r} : '0;
            if (rx_push)
                rx_nib_r <= wdata_r[3:0];
            rx_pend_r <= rx_push || (rx_pend_r && !rx_fall);
        end
    end

    // ----------------------------------------------------------------
    // Outputs, all from flip-flops
    // ----------------------------------------------------------------
    assign axi_o              = rsp_r;
    assign strap_pin_o        = pins_r;
    assign strap_pin_oe_n     = oe_n_r;
    assign mii_rxc            = rxc_r;
    assign mii_rx_o           = rx_r;
    assign mgmt_addr          = {2'b00, cfg_r.addr_lo};
    assign addr_zero_bcast    = bcast_r;
    assign repeater_pair_mode = pair_r;
    assign mode_reserved      = rsvd_r;
    assign isolate            = ctrl_r[`CTRL_ISO];
    assign speed_100          = ctrl_r[`CTRL_SPEED];
    assign full_duplex        = ctrl_r[`CTRL_DUPLEX];

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    rx_clock_sync_a: assert property (
        $changed(rx_r) |-> $fell(rxc_r))
        else $error("receive nibble moved off the clock fall");
    rx_idle_zero_a: assert property (
        !mii_rx_o.rxdv |-> mii_rx_o.rxd == 4'h0)
        else $error("receive data not quiet while invalid");
    tx_take_a: assert property (
        tx_rise && t3_r.txen |=> tx_new_r && tx_nib_r == $past(t3_r.txd))
        else $error("enabled transmit nibble not taken");
    tx_ignore_a: assert property (
        !(tx_rise && t3_r.txen) |=> $stable(tx_nib_r))
        else $error("transmit nibble changed without enable");
    addr_map_a: assert property (
        take |=> mgmt_addr == {2'b00, $past(s3_r.addr_lo)})
        else $error("management address not taken from straps");
    zero_unique_a: assert property (
        st_r == CAP_DONE && cfg_r.zero_unique |-> !addr_zero_bcast)
        else $error("address zero broadcast despite strap");
    zero_bcast_a: assert property (
        st_r == CAP_DONE && cfg_r.addr_lo == 3'd0 && !cfg_r.zero_unique
        |-> addr_zero_bcast)
        else $error("address zero not broadcast");
    pair_mode_a: assert property (
        st_r == CAP_DONE |-> repeater_pair_mode == (cfg_r.mode == 3'b110))
        else $error("repeater pair mode mismatch");
    ctrl_preset_a: assert property (
        take |=> isolate == $past(s3_r.iso) && speed_100 == $past(s3_r.speed)
                 && full_duplex == !$past(s3_r.duplex))
        else $error("control bits not preset from straps");
    pins_input_a: assert property (
        st_r != CAP_DONE |-> strap_pin_oe_n == 10'h3ff)
        else $error("strap pin driven before capture");
    cap_hold_a: assert property (
        st_r == CAP_DONE |=> $stable(cfg_r) [*3])
        else $error("captured straps changed");

    cover property (tx_rise && t3_r.txen);
    cover property (mii_rx_o.rxdv ##4 !mii_rx_o.rxdv);
    cover property (st_r == CAP_DONE && repeater_pair_mode);
    cover property (rsp_r.bvalid && rsp_r.bresp == `RESP_SLVERR);
endmodule

// [testbench/mac_model.sv]
// MAC-side partner: sends transmit nibbles, watches the receive path
`timescale 1ns/1ns

module mac_model (
    output strap_pkg::mii_tx_t    tx,       // Toward device
    input  wire logic             rxc,      // Receive clock from device
    input  wire strap_pkg::mii_rx_t rx,     // Receive nibble path
    output logic [3:0]            rx_last,  // Last valid nibble
    output int                    rx_count  // Valid rxc rises seen
);
    import strap_pkg::*;

    initial
    begin
        tx = '0;
        rx_last = 4'h0;
        rx_count = 0;
    end

    // Sample on rxc rise, clear of the fall where the device moves data
    always @(posedge rxc)
    begin
        if (rx.rxdv)
        begin
            rx_last <= rx.rxd;
            rx_count <= rx_count + 1;
        end
    end

    // One 80 ns link period; clock stands low outside the frame
    task automatic send(input logic en, input logic [3:0] nib);
        tx.txen <= en;
        tx.txd <= nib;
        #40 tx.txc <= 1'b1;
        #40 tx.txc <= 1'b0;
        tx.txen <= 1'b0;
        tx.txd <= ~nib; // Stale nibble must not look valid
    endtask
endmodule

// [testbench/strap_config_latch_bench.sv]
// Self-checking bench for the strap latch
`timescale 1ns/1ns
`include "strap_defines.svh"

module strap_config_latch_bench;
    import strap_pkg::*;

    logic        clock;
    logic        arst_n;
    logic        drv_en;
    logic [9:0]  drv;
    axi_req_t    axi_req;
    axi_rsp_t    axi_rsp;
    strap_cfg_t  pin_i;
    strap_cfg_t  pin_o;
    strap_cfg_t  pin_oe_n;
    mii_tx_t     mii_tx;
    mii_rx_t     mii_rx;
    logic        rxc;
    logic        bcast;
    logic        pair;
    logic        resv;
    logic        iso;
    logic        spd;
    logic        fd;
    logic [4:0]  addr;
    logic [3:0]  rx_last;
    int          rx_count;
    int          mismatches;
    int          n_tests;
    int          i;
    int          k;
    int          n;
    logic [31:0] d;
    logic [1:0]  r;
    logic [9:0]  c;

    // Rows: drive, straps {zu,dup,spd,iso,mode,addr}, expected outputs
    logic [21:0] rows [8] = '{
        22'b0_0110000001_00001000010, 22'b1_0001110000_00000110101,
        22'b1_1110111000_00000001010, 22'b1_0110001111_00111001010,
        22'b1_0110010010_00010001010, 22'b1_0110011011_00011001010,
        22'b1_0110100100_00100001010, 22'b1_0110101101_00101001010};

    wire [10:0] outs = {addr, bcast, pair, resv, iso, spd, fd};

    // Pin resolves: device drive wins, else bench strap, else pulls
    assign pin_i = (~pin_oe_n & pin_o)
                 | (pin_oe_n & (drv_en ? drv : `STRAP_RESET));

    always #5 clock = ~clock;

    strap_config_latch strap_config_latch_inst (
        .clock(clock), .arst_n(arst_n), .axi_i(axi_req), .axi_o(axi_rsp),
        .strap_pin_i(pin_i), .strap_pin_o(pin_o),
        .strap_pin_oe_n(pin_oe_n), .mii_tx_i(mii_tx), .mii_rxc(rxc),
        .mii_rx_o(mii_rx), .mgmt_addr(addr), .addr_zero_bcast(bcast),
        .repeater_pair_mode(pair), .mode_reserved(resv), .isolate(iso),
        .speed_100(spd), .full_duplex(fd));

    mac_model mac_model_inst (
        .tx(mii_tx), .rxc(rxc), .rx(mii_rx), .rx_last(rx_last),
        .rx_count(rx_count));

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task results;
        $display("mismatches %0d comparisons %0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task hang;
        mismatches++;
        results;
    endtask

    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
            mismatches++;
        end
    endtask

    // Both channels offered together, each dropped as it is taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v,
                          output logic [1:0] rs);
        int j;
        @(posedge clock);
        axi_req.awvalid <= 1'b1;
        axi_req.awaddr <= a;
        axi_req.wvalid <= 1'b1;
        axi_req.wdata <= v;
        axi_req.wstrb <= 4'hf;
        axi_req.bready <= 1'b1;
        for (j = 0; j < 40; j++)
        begin
            @(posedge clock);
            if (axi_req.awvalid && axi_rsp.awready)
                axi_req.awvalid <= 1'b0;
            if (axi_req.wvalid && axi_rsp.wready)
                axi_req.wvalid <= 1'b0;
            if (axi_rsp.bvalid)
                break;
        end
        if (j == 40)
            hang;
        rs = axi_rsp.bresp;
        axi_req.bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] v,
                          output logic [1:0] rs);
        int j;
        @(posedge clock);
        axi_req.arvalid <= 1'b1;
        axi_req.araddr <= a;
        axi_req.rready <= 1'b1;
        for (j = 0; j < 40; j++)
        begin
            @(posedge clock);
            if (axi_req.arvalid && axi_rsp.arready)
                axi_req.arvalid <= 1'b0;
            if (axi_rsp.rvalid)
                break;
        end
        if (j == 40)
            hang;
        v = axi_rsp.rdata;
        rs = axi_rsp.rresp;
        axi_req.rready <= 1'b0;
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        clock = 1'b0;
        arst_n = 1'b0;
        axi_req = '0;
        drv = 10'h000;
        drv_en = 1'b0;
        mismatches = 0;
        n_tests = 0;
        // Each row is a fresh reset, so mid-run resets come for free
        for (k = 0; k < 8; k++)
        begin
            c = rows[k][20:11];
            @(posedge clock);
            drv <= c;
            drv_en <= rows[k][21];
            arst_n <= 1'b0;
            repeat (3) @(posedge clock);
            arst_n <= 1'b1;
            @(posedge clock);
            check(pin_oe_n, 10'h3ff);
            for (i = 0; i < 20 && pin_oe_n !== 10'h000; i++)
                @(posedge clock);
            if (i == 20)
                hang;
            @(posedge clock);
            check(outs, rows[k][10:0]);
            check(bcast, c[2:0] == 3'h0 && !c[9]);
            check(fd, !c[8]);
            axi_rd(`OFF_CTRL, d, r);
            check(d, {18'h0, c[7], 2'h0, c[6], 1'h0, ~c[8], 8'h00});
            axi_rd(`OFF_ADV, d, r);
            check(d, {24'h0, c[7], 2'h1, 5'h00});
            // Device now owns the pins; flip them and expect no recapture
            axi_wr(`OFF_PINS, {22'h0, ~c}, r);
            repeat (3) @(posedge clock);
            check(pin_i, {22'h0, ~c});
            check(outs, rows[k][10:0]);
            $display("row %0d done", k);
        end
        axi_wr(`OFF_CTRL, 32'h0000_0500, r);
        axi_rd(`OFF_CTRL, d, r);
        check(d, 32'h0000_0500);
        check({iso, spd, fd}, 3'h5);
        $display("ctrl write done");
        axi_wr(8'h20, 32'h0000_0001, r);
        check(r, `RESP_SLVERR);
        axi_rd(8'h20, d, r);
        check(d, 32'h0);
        check(r, `RESP_SLVERR);
        $display("unmapped done");
        // Transmit: enabled nibble lands, disabled one leaves no trace
        mac_model_inst.send(1'h1, 4'ha);
        for (i = 0; i < 20; i++)
        begin
            axi_rd(`OFF_MII, d, r);
            if (d[4] === 1'b1)
                break;
        end
        check(d[4:0], 5'h1a);
        axi_wr(`OFF_MII, 32'h0000_0020, r);
        mac_model_inst.send(1'h0, 4'h5);
        repeat (8) @(posedge clock);
        axi_rd(`OFF_MII, d, r);
        check(d[4:0], 5'h0a);
        $display("transmit done");
        // Receive: one queued nibble gives exactly one valid period
        n = rx_count;
        axi_wr(`OFF_MII, 32'h0000_0016, r);
        for (i = 0; i < 20 && rx_count == n; i++)
            @(posedge clock);
        if (i == 20)
            hang;
        check(rx_last, 4'h6);
        repeat (8) @(posedge clock);
        check(rx_count - n, 1);
        $display("receive done");
        results;
    end
endmodule
